// [core/nes_pkg.sv]
// Purpose: shared constants and types for the nvm erase/write sequencer link
// Assumes: 40 MHz system clock on both ends
// Notes:   one package serves the device end, the programmer end and the bench
package nes_pkg;

  // serial command framing
  localparam int          CMD_BITS       = 4;
  localparam int          INSTR_BITS     = 24;
  localparam int          FORCED_EXTRA   = 5;          // extra clocks of the first code after reset
  localparam int          READOUT_IDLE   = 8;
  localparam int          READOUT_BITS   = 16;
  localparam logic [3:0]  CMD_SHIFT_EXEC = 4'h0;       // shift_execute_cmd
  localparam logic [3:0]  CMD_SHIFT_READ = 4'h1;       // shift_readout_cmd

  // nvm_control_reg operation codes
  localparam logic [15:0] OP_BULK        = 16'h4064;
  localparam logic [15:0] OP_GEN_SEG     = 16'h404C;
  localparam logic [15:0] OP_BOOT_SEG    = 16'h4068;
  localparam logic [15:0] OP_ERASE_4     = 16'h405A;
  localparam logic [15:0] OP_ERASE_2     = 16'h4059;
  localparam logic [15:0] OP_ERASE_1     = 16'h4058;
  localparam logic [15:0] OP_EE_ALL      = 16'h4050;
  localparam logic [15:0] OP_CFG_ALL     = 16'h4054;
  localparam logic [15:0] OP_WRITE       = 16'h4004;
  localparam int          START_BIT      = 15;

  // erase and write sizes
  localparam logic [5:0]  ROW_WORDS      = 6'd32;
  localparam logic [5:0]  ERASE4_ROWS    = 6'd4;
  localparam logic [5:0]  ERASE4_WORDS   = 6'd8;
  localparam logic [5:0]  ERASE2_ROWS    = 6'd2;
  localparam logic [5:0]  ERASE2_WORDS   = 6'd4;
  localparam logic [5:0]  SINGLE_UNIT    = 6'd1;
  localparam logic [5:0]  WHOLE_AREA     = 6'd0;

  // data space addresses of the special registers
  localparam logic [15:0] CTL_ADDR       = 16'h0760;
  localparam logic [15:0] PAGE_ADDR      = 16'h0032;
  localparam logic [15:0] READOUT_ADDR   = 16'h0784;

  // destination address regions
  localparam logic [23:0] EE_BASE        = 24'h7F_FE00;
  localparam logic [23:0] CFG_BASE       = 24'hF8_0000;

  // instruction words used by the bulk erase sequence
  localparam logic [23:0] INSTR_NOP      = 24'h00_0000;
  localparam logic [23:0] INSTR_GOTO_200 = 24'h04_0200;
  localparam logic [23:0] INSTR_LIT_BULK = 24'h24_064A;
  localparam logic [23:0] INSTR_W10_CTL  = 24'h88_3B0A;
  localparam logic [23:0] INSTR_LIT_W0   = 24'h20_0000;
  localparam logic [23:0] INSTR_W0_PAGE  = 24'h88_0190;
  localparam logic [23:0] INSTR_TBLWT    = 24'hBB_0800;
  localparam logic [23:0] INSTR_BIT_SET  = 24'hA8_E761;
  localparam logic [23:0] INSTR_CTL_W2   = 24'h80_3B02;
  localparam logic [23:0] INSTR_W2_READ  = 24'h88_3C22;

  // self-timed cycle lengths
  localparam int          CLK_HZ         = 40_000_000;
  localparam int          ERASE_TIME_US  = 4000;
  localparam int          WRITE_TIME_US  = 2000;
  localparam int          ERASE_CYCLES   = ERASE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int          WRITE_CYCLES   = WRITE_TIME_US * (CLK_HZ / 1_000_000);

  // programmer link timing
  localparam int          HALF_CLKS      = 4;
  localparam int          RST_PGC        = 4;

  typedef enum logic [2:0] {
    NES_OP_NONE, NES_OP_BULK, NES_OP_GEN_SEG, NES_OP_BOOT_SEG,
    NES_OP_ERASE_PART, NES_OP_EE_ALL, NES_OP_CFG_ALL, NES_OP_WRITE
  } nes_op_e;

  typedef enum logic [1:0] {NES_RG_CODE, NES_RG_EE, NES_RG_CFG} nes_region_e;

  typedef struct packed {
    nes_op_e    op;
    logic [5:0] units;
  } nes_job_s;

endpackage

// [core/nes_link_if.sv]
// Purpose: serial programming link between programmer and device
// Assumes: the data line is pulled high when neither end drives it
// Notes:   device drive wins if both enables are ever high together
`timescale 1ns/1ps
interface nes_link_if;
  logic prog_serial_clock;
  logic prog_reset;
  logic prg_data_o;
  logic prg_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic prog_serial_data;

  // resolved line level
  assign prog_serial_data = dev_data_oe ? dev_data_o : (prg_data_oe ? prg_data_o : 1'b1);

  modport device (input prog_serial_clock, prog_reset, prog_serial_data, output dev_data_o, dev_data_oe);
  modport programmer (output prog_serial_clock, prog_reset, prg_data_o, prg_data_oe, input prog_serial_data);
endinterface

// [core/nes_device.sv]
// Purpose: device end: serial command engine, control register and self-timed nvm cycle
// Assumes: link logic runs on the programming clock, the cycle timer on clk_i
// Notes:   the memory array itself is outside; this block reports what to erase or write
`timescale 1ns/1ps

// Summary of operation
// - 4064h erases code and config, keeps executive/id
// - 404Ch erases general segment with its config
// - 4068h erases boot segment with its config
// - code region: 405A/9/8h erase four/two/one rows
// - 4050h erases whole data eeprom and config
// - eeprom region: 405A/9/8h erase eight/four/one words
// - 4054h erases config except code-protect fuses
// - config region 4058h spares segment protection registers
// - destination address picks code, eeprom or config
// - 4004h writes config word, 32-word row, eeprom word
// - setting control bit 15 starts the cycle
// - cycle self-timed, start bit clears when done
// - programmer polls start bit until clear
// - programmer bulk-erases by loading 4064h then cycling
// - programmer shifts code and payload lsb first
// - programmer erases before writing program memory
// - sequence opens with nop, jump 0x200, nop
// - page write, dummy table write, two nops
// - bit-set start instruction then two nops
// - poll: jump, copy control to readout, shift out
// - code 0000b shifts in and executes 24-bit instruction
// - code 0001b idles 8 then shifts readout 16
// - data changes falling, captured rising, lsb first
module nes_device
  import nes_pkg::*;
#(
  parameter int ERASE_CYC = nes_pkg::ERASE_CYCLES,
  parameter int WRITE_CYC = nes_pkg::WRITE_CYCLES
) (
  // system
  input  logic                clk_i,
  input  logic                reset_i,
  // programming link
  nes_link_if.device          link,
  // nvm array side
  output logic                nvm_busy_o,
  output logic                nvm_start_o,
  output logic                nvm_done_o,
  output nes_pkg::nes_op_e    nvm_op_o,
  output nes_pkg::nes_region_e nvm_region_o,
  output logic [5:0]          nvm_units_o,
  output logic [23:0]         nvm_addr_o
);
  import nes_pkg::*;

  localparam logic [5:0] CMD_LAST    = 6'(CMD_BITS - 1);
  localparam logic [5:0] FIRST_LAST  = 6'(CMD_BITS + FORCED_EXTRA - 1);
  localparam logic [5:0] INSTR_LAST  = 6'(INSTR_BITS - 1);
  localparam logic [5:0] IDLE_LAST   = 6'(READOUT_IDLE - 1);
  localparam logic [5:0] OUT_LAST    = 6'(READOUT_BITS - 1);

  typedef enum logic [1:0] {
    NES_L_CMD  = 2'b00,
    NES_L_INS  = 2'b01,
    NES_L_IDLE = 2'b11,
    NES_L_OUT  = 2'b10
  } nes_lst_e;

  typedef struct packed {
    nes_lst_e          st;
    logic [5:0]        cnt;
    logic              first;
    logic [23:0]       sh;
    logic [3:0]        cmd;
    logic [15:0][15:0] w;
    logic [14:0]       ctl;
    logic [7:0]        page;
    logic [15:0]       readout;
    logic [23:0]       dest;
    logic              busy;
    logic              start_tgl;
    logic [15:0]       cyc_code;
    logic [23:0]       cyc_addr;
    logic [2:0]        done_sync;
    logic              done_seen;
  } nes_dlink_s;

  typedef struct packed {
    logic              oe;
    logic              dat;
  } nes_dout_s;

  typedef struct packed {
    logic [2:0]        start_sync;
    logic              start_seen;
    logic              busy;
    logic [31:0]       timer;
    logic              done_tgl;
    logic              start_p;
    logic              done_p;
    nes_job_s          job;
    nes_region_e       region;
    logic [23:0]       addr;
  } nes_dsys_s;

  nes_dlink_s lk_q, lk_d;
  nes_dout_s  out_q;
  nes_dsys_s  sy_q, sy_d;

  // region from the destination address
  function automatic nes_region_e region_of(input logic [23:0] a);
    if (a >= CFG_BASE) return NES_RG_CFG;
    if (a >= EE_BASE)  return NES_RG_EE;
    return NES_RG_CODE;
  endfunction

  // operation code and region to the job handed to the array
  function automatic nes_job_s job_of(input logic [15:0] c, input nes_region_e r);
    nes_job_s j;
    j = '{op: NES_OP_NONE, units: WHOLE_AREA};
    unique case (c)
      OP_BULK:     j.op = NES_OP_BULK;     // array keeps executive and id area
      OP_GEN_SEG:  j.op = NES_OP_GEN_SEG;
      OP_BOOT_SEG: j.op = NES_OP_BOOT_SEG;
      OP_EE_ALL:   j.op = NES_OP_EE_ALL;
      OP_CFG_ALL:  j.op = NES_OP_CFG_ALL;
      OP_ERASE_4:  j = '{op: NES_OP_ERASE_PART, units: (r == NES_RG_EE) ? ERASE4_WORDS : ERASE4_ROWS};
      OP_ERASE_2:  j = '{op: NES_OP_ERASE_PART, units: (r == NES_RG_EE) ? ERASE2_WORDS : ERASE2_ROWS};
      OP_ERASE_1:  j = '{op: NES_OP_ERASE_PART, units: SINGLE_UNIT};
      OP_WRITE:    j = '{op: NES_OP_WRITE, units: (r == NES_RG_CODE) ? ROW_WORDS : SINGLE_UNIT};
      default:     j.op = NES_OP_NONE;
    endcase
    return j;
  endfunction

  // link side: command shift, instruction execute, start and busy
  always_comb begin
    logic [23:0] ins;
    logic [15:0] fa;
    logic [15:0] wv;
    logic [3:0]  nc;
    logic        go;
    ins = {link.prog_serial_data, lk_q.sh[23:1]}; // lsb arrives first
    nc  = {link.prog_serial_data, lk_q.cmd[3:1]};
    fa  = {ins[18:4], 1'b0};
    wv  = lk_q.w[ins[3:0]];
    go  = 1'b0;
    lk_d = lk_q;
    lk_d.done_sync = {lk_q.done_sync[1:0], sy_q.done_tgl};
    // completion seen once the last two stages agree
    if (lk_q.done_sync[1] == lk_q.done_sync[2] && lk_q.done_sync[2] != lk_q.done_seen) begin
      lk_d.done_seen = lk_q.done_sync[2];
      lk_d.busy      = 1'b0;
    end
    unique case (lk_q.st)
      NES_L_CMD: begin
        lk_d.cmd = nc;
        lk_d.cnt = lk_q.cnt + 6'd1;
        if (lk_q.cnt == (lk_q.first ? FIRST_LAST : CMD_LAST)) begin
          lk_d.cnt   = '0;
          lk_d.first = 1'b0;
          // first code after reset is forced to execute; reserved codes are dropped
          if (lk_q.first || nc == CMD_SHIFT_EXEC) begin
            lk_d.st = NES_L_INS;
          end else if (nc == CMD_SHIFT_READ) begin
            lk_d.st = NES_L_IDLE;
          end
        end
      end
      NES_L_INS: begin
        lk_d.sh  = ins;
        lk_d.cnt = lk_q.cnt + 6'd1;
        if (lk_q.cnt == INSTR_LAST) begin
          lk_d.st  = NES_L_CMD;
          lk_d.cnt = '0;
          if (ins[23:20] == 4'h2) begin // move literal to working register
            lk_d.w[ins[3:0]] = ins[19:4];
          end else if (ins[23:19] == 5'b10001) begin // register to data space
            if (fa == CTL_ADDR && !lk_q.busy) begin
              lk_d.ctl = wv[14:0];
              go = wv[START_BIT];
            end else if (fa == PAGE_ADDR) begin
              lk_d.page = wv[7:0];
            end else if (fa == READOUT_ADDR) begin
              lk_d.readout = wv;
            end
          end else if (ins[23:19] == 5'b10000) begin // data space to register
            if (fa == CTL_ADDR) lk_d.w[ins[3:0]] = {lk_q.busy, lk_q.ctl};
            else if (fa == PAGE_ADDR) lk_d.w[ins[3:0]] = {8'h00, lk_q.page};
            else if (fa == READOUT_ADDR) lk_d.w[ins[3:0]] = lk_q.readout;
          end else if (ins[23:16] == 8'hA8 && {ins[12:1], 1'b0} == CTL_ADDR[12:0] && !lk_q.busy) begin
            // bit set on the control register
            if ({ins[15:13], ins[0]} == 4'(START_BIT)) go = 1'b1;
            else lk_d.ctl[{ins[15:13], ins[0]}] = 1'b1;
          end else if (ins[23:19] == 5'b10111) begin // table write latches destination
            lk_d.dest = {lk_q.page, lk_q.w[ins[10:7]]};
          end
        end
      end
      NES_L_IDLE: begin
        lk_d.cnt = lk_q.cnt + 6'd1;
        if (lk_q.cnt == IDLE_LAST) begin
          lk_d.st  = NES_L_OUT;
          lk_d.cnt = '0;
        end
      end
      NES_L_OUT: begin
        lk_d.cnt = lk_q.cnt + 6'd1;
        if (lk_q.cnt == OUT_LAST) begin
          lk_d.st  = NES_L_CMD;
          lk_d.cnt = '0;
        end
      end
    endcase
    // start ignored while busy; code and address frozen for the timer side
    if (go && !lk_q.busy) begin
      lk_d.busy      = 1'b1;
      lk_d.start_tgl = ~lk_q.start_tgl;
      lk_d.cyc_code  = {1'b0, lk_d.ctl};
      lk_d.cyc_addr  = lk_q.dest;
    end
  end

  always_ff @(posedge link.prog_serial_clock) begin
    if (link.prog_reset) begin
      lk_q       <= '0;
      lk_q.first <= 1'b1;
    end else begin
      lk_q <= lk_d;
    end
  end

  // readout bits launched on the falling edge so the far end captures on rising
  always_ff @(negedge link.prog_serial_clock) begin
    if (link.prog_reset) begin
      out_q <= '0;
    end else begin
      out_q.oe  <= (lk_q.st == NES_L_OUT);
      out_q.dat <= lk_q.readout[lk_q.cnt[3:0]];
    end
  end

  assign link.dev_data_o  = out_q.dat;
  assign link.dev_data_oe = out_q.oe;

  // system side: self-timed cycle driven by a toggle from the link side
  always_comb begin
    nes_job_s j;
    j = job_of(lk_q.cyc_code[15:0], region_of(lk_q.cyc_addr));
    sy_d = sy_q;
    sy_d.start_sync = {sy_q.start_sync[1:0], lk_q.start_tgl};
    sy_d.start_p = 1'b0;
    sy_d.done_p  = 1'b0;
    if (sy_q.start_sync[1] == sy_q.start_sync[2] && sy_q.start_sync[2] != sy_q.start_seen) begin
      sy_d.start_seen = sy_q.start_sync[2];
      sy_d.busy    = 1'b1;
      sy_d.start_p = 1'b1;
      sy_d.job     = j;
      sy_d.region  = region_of(lk_q.cyc_addr);
      sy_d.addr    = lk_q.cyc_addr;
      // an unknown code still completes so the start bit always clears
      if (j.op == NES_OP_NONE) sy_d.timer = 32'd1;
      else if (j.op == NES_OP_WRITE) sy_d.timer = 32'(WRITE_CYC);
      else sy_d.timer = 32'(ERASE_CYC);
    end else if (sy_q.busy) begin
      if (sy_q.timer <= 32'd1) begin
        sy_d.busy     = 1'b0;
        sy_d.done_p   = 1'b1;
        sy_d.done_tgl = ~sy_q.done_tgl;
      end else begin
        sy_d.timer = sy_q.timer - 32'd1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sy_q <= '0;
    end else begin
      sy_q <= sy_d;
    end
  end

  // array-side outputs straight from flops
  assign nvm_busy_o   = sy_q.busy;
  assign nvm_start_o  = sy_q.start_p;
  assign nvm_done_o   = sy_q.done_p;
  assign nvm_op_o     = sy_q.job.op;
  assign nvm_units_o  = sy_q.job.units;
  assign nvm_region_o = sy_q.region;
  assign nvm_addr_o   = sy_q.addr;

endmodule // nes_device

// [core/nes_programmer.sv]
// Purpose: programmer end: clock divider, frame engine, bulk erase sequencer, raw command port
// Assumes: the programmer makes the link clock from clk_i by division
// Notes:   raw commands are only accepted after a completed bulk erase
`timescale 1ns/1ps
module nes_programmer
  import nes_pkg::*;
#(
  parameter int HALF = nes_pkg::HALF_CLKS
) (
  // system
  input  logic        clk_i,
  input  logic        reset_i,
  // programming link
  nes_link_if.programmer link,
  // bulk erase
  input  logic        bulk_start_i,
  output logic        bulk_busy_o,
  output logic        bulk_done_o,
  // raw commands
  input  logic        cmd_valid_i,
  input  logic        cmd_read_i,
  input  logic [23:0] cmd_instr_i,
  output logic        cmd_ready_o,
  output logic        resp_valid_o,
  output logic [15:0] resp_data_o
);
  import nes_pkg::*;

  localparam logic [7:0] HALF_LAST = 8'(HALF - 1);
  localparam logic [5:0] LEN_NORM  = 6'(CMD_BITS + INSTR_BITS);
  localparam logic [5:0] LEN_FIRST = 6'(CMD_BITS + FORCED_EXTRA + INSTR_BITS);
  localparam logic [5:0] RX_FIRST  = 6'(CMD_BITS + READOUT_IDLE);
  localparam logic [5:0] RST_LAST  = 6'(RST_PGC - 1);
  localparam logic [4:0] POLL_PC   = 5'd14;
  localparam logic [4:0] LAST_PC   = 5'd21;

  typedef enum logic [1:0] {NES_P_RST = 2'b00, NES_P_IDLE = 2'b01, NES_P_LOW = 2'b11, NES_P_HIGH = 2'b10} nes_ph_e;

  typedef struct packed {
    nes_ph_e     ph;
    logic [7:0]  div;
    logic [5:0]  idx;
    logic [5:0]  len;
    logic [32:0] sh;
    logic        ro;
    logic        src_seq;
    logic [15:0] rx;
    logic        first;
    logic        mclr;
    logic        pgc;
    logic        oe;
    logic        dat;
    logic [2:0]  din_sync;
    logic        din;
    logic        seq;
    logic [4:0]  pc;
    logic        polled;
    logic        erased;
    logic        ready;
    logic        resp_v;
    logic [15:0] resp;
    logic        bdone;
  } nes_prg_s;

  nes_prg_s q, d;

  // bulk erase script: {readout, instruction}
  function automatic logic [24:0] seq_step(input logic [4:0] pc);
    unique case (pc)
      5'd1, 5'd15: return {1'b0, INSTR_GOTO_200};
      5'd3:        return {1'b0, INSTR_LIT_BULK};
      5'd4:        return {1'b0, INSTR_W10_CTL};
      5'd5, 5'd7:  return {1'b0, INSTR_LIT_W0};
      5'd6:        return {1'b0, INSTR_W0_PAGE};
      5'd8:        return {1'b0, INSTR_TBLWT};
      5'd11:       return {1'b0, INSTR_BIT_SET};
      5'd17:       return {1'b0, INSTR_CTL_W2};
      5'd18:       return {1'b0, INSTR_W2_READ};
      5'd20:       return {1'b1, INSTR_NOP};      // shift out readout
      default:     return {1'b0, INSTR_NOP};
    endcase
  endfunction

  always_comb begin
    logic        go;
    logic [24:0] req;
    logic [32:0] nsh;
    go  = 1'b0;
    req = '0;
    nsh = '0;
    d = q;
    d.resp_v = 1'b0;
    d.bdone  = 1'b0;
    // data pin: three stages, a change counts once the last two agree
    d.din_sync = {q.din_sync[1:0], link.prog_serial_data};
    if (q.din_sync[1] == q.din_sync[2]) d.din = q.din_sync[2];
    unique case (q.ph)
      NES_P_RST: begin
        // clocks run with reset held so the device sees it on its own edges
        d.div = q.div + 8'd1;
        if (q.div == HALF_LAST) begin
          d.div = '0;
          d.pgc = ~q.pgc;
          if (q.pgc) begin
            d.idx = q.idx + 6'd1;
            if (q.idx == RST_LAST) begin
              d.mclr = 1'b0;
              d.ph   = NES_P_IDLE;
              d.idx  = '0;
            end
          end
        end
      end
      NES_P_IDLE: begin
        if (q.seq) begin
          go = 1'b1;
          req = seq_step(q.pc);
          d.src_seq = 1'b1;
        end else if (cmd_valid_i && q.ready) begin // ready only after erase
          go = 1'b1;
          req = {cmd_read_i, cmd_instr_i};
          d.src_seq = 1'b0;
        end else if (bulk_start_i) begin
          d.seq = 1'b1;
          d.pc  = '0;
        end
      end
      NES_P_LOW: begin
        d.div = q.div + 8'd1;
        if (q.div == HALF_LAST) begin
          d.div = '0;
          d.ph  = NES_P_HIGH;
          d.pgc = 1'b1; // device captures on this rise
        end
      end
      NES_P_HIGH: begin
        d.div = q.div + 8'd1;
        if (q.div == HALF_LAST) begin
          d.div = '0;
          if (q.ro && q.idx >= RX_FIRST) d.rx = {q.din, q.rx[15:1]};
          d.pgc = 1'b0;
          if (q.idx == q.len - 6'd1) begin
            d.ph = NES_P_IDLE;
            d.oe = 1'b0;
            if (q.ro && !q.src_seq) begin
              d.resp_v = 1'b1;
              d.resp   = d.rx;
            end
            if (q.ro && q.src_seq) d.polled = d.rx[START_BIT];
            if (q.src_seq) begin
              if (q.pc != LAST_PC) begin
                d.pc = q.pc + 5'd1;
              end else if (q.polled) begin
                d.pc = POLL_PC; // still busy, poll again
              end else begin
                d.seq    = 1'b0;
                d.erased = 1'b1;
                d.bdone  = 1'b1;
              end
            end
          end else begin
            d.idx = q.idx + 6'd1;
            d.sh  = q.sh >> 1;
            d.ph  = NES_P_LOW;
            d.dat = q.sh[1]; // change while clock is low
            d.oe  = !q.ro || (q.idx + 6'd1) < 6'(CMD_BITS);
          end
        end
      end
    endcase
    // frame load: code then payload, lsb first; forced first code padded
    if (go) begin
      nsh = q.first ? {req[23:0], 9'h000}
                    : {5'h00, req[23:0], (req[24] ? CMD_SHIFT_READ : CMD_SHIFT_EXEC)};
      d.sh    = nsh;
      d.len   = q.first ? LEN_FIRST : LEN_NORM;
      d.ro    = req[24] && !q.first;
      d.first = 1'b0;
      d.ph    = NES_P_LOW;
      d.div   = '0;
      d.idx   = '0;
      d.dat   = nsh[0];
      d.oe    = 1'b1;
    end
    d.ready = (d.ph == NES_P_IDLE) && !d.seq && d.erased && !go && !bulk_start_i;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q       <= '0;
      q.ph    <= NES_P_RST;
      q.first <= 1'b1;
      q.mclr  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.prog_serial_clock = q.pgc;
  assign link.prog_reset        = q.mclr;
  assign link.prg_data_o        = q.dat;
  assign link.prg_data_oe       = q.oe;
  assign bulk_busy_o            = q.seq;
  assign bulk_done_o            = q.bdone;
  assign cmd_ready_o            = q.ready;
  assign resp_valid_o           = q.resp_v;
  assign resp_data_o            = q.resp;

endmodule // nes_programmer

// [tb/nes_link_sva.sv]
// Purpose: timing checks on the programming link
// Assumes: link signals sampled on clk_i
// Notes:   phase repeats assume HALF of 4
`timescale 1ns/1ps
module nes_link_sva #(
  parameter int HALF = 4
) (
  // system
  input logic clk_i,
  input logic reset_i,
  // link
  input logic prog_serial_clock,
  input logic prog_reset,
  input logic prg_data_o,
  input logic prg_data_oe,
  input logic dev_data_o,
  input logic dev_data_oe
);
  logic [9:0] oe_cnt_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // device drive length, judged when it ends
  always_ff @(posedge clk_i) begin
    oe_cnt_q <= (reset_i || !dev_data_oe) ? 10'h000 : oe_cnt_q + 10'h001;
  end
  property p_no_clash; !(dev_data_oe && prg_data_oe); endproperty
  property p_high; $rose(prog_serial_clock) |-> prog_serial_clock [*4]; endproperty
  property p_low; $fell(prog_serial_clock) |-> !prog_serial_clock [*4]; endproperty
  property p_prg_chg; prg_data_oe && $changed(prg_data_o) |-> !prog_serial_clock; endproperty
  property p_dev_chg; $changed(dev_data_o) |-> $fell(prog_serial_clock); endproperty
  property p_oe_edge; $changed(dev_data_oe) |-> $fell(prog_serial_clock); endproperty
  property p_oe_len; $fell(dev_data_oe) && !prog_reset |-> oe_cnt_q == 10'(32 * HALF); endproperty
  property p_rst_drop; $fell(prog_reset) |-> !prog_serial_clock; endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
  a_high: assert property (p_high) else $error("clock high phase short");
  a_low: assert property (p_low) else $error("clock low phase short");
  a_prg_chg: assert property (p_prg_chg) else $error("host data moved, clock high");
  a_dev_chg: assert property (p_dev_chg) else $error("device data moved off a fall");
  a_oe_edge: assert property (p_oe_edge) else $error("device drive edge off a fall");
  a_oe_len: assert property (p_oe_len) else $error("readout drive length wrong");
  a_rst_drop: assert property (p_rst_drop) else $error("link reset left, clock high");
  c_read: cover property ($rose(dev_data_oe));
  c_run: cover property ($fell(prog_reset));
  c_frame: cover property ($rose(prg_data_oe));
endmodule // nes_link_sva

// [tb/testbench.sv]
// Purpose: both ends joined, erase and write codes driven raw
// Assumes: 40 MHz clk_i, shortened cycle timers
// Notes:   addresses random from a fixed seed, except the fixed EE_BASE and CFG_BASE - 1 cases
`timescale 1ns/1ps
module testbench;
  import nes_pkg::*;
  logic        clk_i = 1'b0, reset_i = 1'b1, bulk_start_i = 1'b0, cmd_valid_i = 1'b0, cmd_read_i = 1'b0;
  logic [23:0] cmd_instr_i = INSTR_NOP, nvm_addr_o, ad;
  logic        bulk_busy_o, bulk_done_o, cmd_ready_o, resp_valid_o, nvm_busy_o, nvm_start_o, nvm_done_o;
  logic [15:0] resp_data_o, rd;
  logic [15:0] ops [12] = '{OP_BULK, OP_GEN_SEG, OP_BOOT_SEG, OP_ERASE_4, OP_ERASE_2, OP_ERASE_1,
                            OP_EE_ALL, OP_ERASE_4, OP_CFG_ALL, OP_WRITE, OP_WRITE, OP_ERASE_2};
  int          rgs [12] = '{0, 0, 0, 0, 4, 2, 0, 3, 0, 0, 1, 2};
  nes_op_e     nvm_op_o;
  nes_region_e nvm_region_o;
  logic [5:0]  nvm_units_o;
  logic [10:0] e;
  int          mismatches = 0, check_count = 0, i, k;
  nes_link_if link ();
  nes_device #(.ERASE_CYC(1500), .WRITE_CYC(800)) i_nes_device (.clk_i(clk_i), .reset_i(reset_i), .link(link),
    .nvm_busy_o(nvm_busy_o), .nvm_start_o(nvm_start_o), .nvm_done_o(nvm_done_o), .nvm_op_o(nvm_op_o),
    .nvm_region_o(nvm_region_o), .nvm_units_o(nvm_units_o), .nvm_addr_o(nvm_addr_o));
  nes_programmer #(.HALF(HALF_CLKS)) i_nes_programmer (.clk_i(clk_i), .reset_i(reset_i), .link(link),
    .bulk_start_i(bulk_start_i), .bulk_busy_o(bulk_busy_o), .bulk_done_o(bulk_done_o), .cmd_valid_i(cmd_valid_i),
    .cmd_read_i(cmd_read_i), .cmd_instr_i(cmd_instr_i), .cmd_ready_o(cmd_ready_o), .resp_valid_o(resp_valid_o),
    .resp_data_o(resp_data_o));
  nes_link_sva #(.HALF(HALF_CLKS)) i_nes_link_sva (.clk_i(clk_i), .reset_i(reset_i),
    .prog_serial_clock(link.prog_serial_clock), .prog_reset(link.prog_reset), .prg_data_o(link.prg_data_o),
    .prg_data_oe(link.prg_data_oe), .dev_data_o(link.dev_data_o), .dev_data_oe(link.dev_data_oe));
  // 40 MHz
  always #12.5 clk_i = ~clk_i;
  // op, region and units for a code and address
  function automatic logic [10:0] exp_f(input logic [15:0] op, input logic [23:0] a);
    nes_region_e r;
    r = a >= CFG_BASE ? NES_RG_CFG : (a >= EE_BASE ? NES_RG_EE : NES_RG_CODE);
    case (op)
      OP_BULK:    return {NES_OP_BULK, r, WHOLE_AREA};
      OP_GEN_SEG: return {NES_OP_GEN_SEG, r, WHOLE_AREA};
      OP_BOOT_SEG: return {NES_OP_BOOT_SEG, r, WHOLE_AREA};
      OP_EE_ALL:  return {NES_OP_EE_ALL, r, WHOLE_AREA};
      OP_CFG_ALL: return {NES_OP_CFG_ALL, r, WHOLE_AREA};
      OP_ERASE_4: return {NES_OP_ERASE_PART, r, r == NES_RG_EE ? ERASE4_WORDS : ERASE4_ROWS};
      OP_ERASE_2: return {NES_OP_ERASE_PART, r, r == NES_RG_EE ? ERASE2_WORDS : ERASE2_ROWS};
      OP_ERASE_1: return {NES_OP_ERASE_PART, r, SINGLE_UNIT};
      default:    return {NES_OP_WRITE, r, r == NES_RG_CODE ? ROW_WORDS : SINGLE_UNIT};
    endcase
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // bounded wait: 0 cycle start, 1 readout answer, 2 bulk done
  task automatic w(input int s);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (n < 20000 && !(s == 0 ? nvm_start_o === 1'b1 : s == 1 ? resp_valid_o === 1'b1 : bulk_done_o === 1'b1));
    if (n >= 20000) begin
      mismatches++;
      close_out();
    end
  endtask
  // request held until taken at a ready edge
  task automatic cmd(input logic r, input logic [23:0] ins);
    int n;
    n = 0;
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_read_i  <= r;
    cmd_instr_i <= ins;
    do begin
      @(posedge clk_i);
      n++;
    end while (cmd_ready_o !== 1'b1 && n < 2000);
    cmd_valid_i <= 1'b0;
    if (n >= 2000) begin
      mismatches++;
      close_out();
    end
    if (r) begin
      w(1);
      rd = resp_data_o;
    end
  endtask
  task automatic poll();
    cmd(1'b0, INSTR_CTL_W2);
    cmd(1'b0, INSTR_W2_READ);
    cmd(1'b1, INSTR_NOP);
  endtask
  initial begin
    k = $urandom(32'hcaca);
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (60) @(posedge clk_i);
    bulk_start_i <= 1'b1;
    @(posedge clk_i);
    bulk_start_i <= 1'b0;
    w(0);
    chk(32'(nvm_op_o), 32'(NES_OP_BULK));
    w(2);
    chk(32'({nvm_busy_o, bulk_busy_o}), 32'h0);
    for (i = 0; i < 12; i++) begin
      ad = rgs[i] == 0 ? {8'($urandom_range(126)), 16'($urandom)} : rgs[i] == 1 ? {16'h7FFE, 8'($urandom)} :
           rgs[i] == 2 ? {8'hF8, 16'($urandom)} : rgs[i] == 3 ? EE_BASE : CFG_BASE - 24'h1;
      cmd(1'b0, {4'h2, ops[i], 4'hA});
      cmd(1'b0, INSTR_W10_CTL);
      cmd(1'b0, {12'h200, ad[23:16], 4'h0});
      cmd(1'b0, INSTR_W0_PAGE);
      cmd(1'b0, {4'h2, ad[15:0], 4'h0});
      cmd(1'b0, INSTR_TBLWT);
      cmd(1'b0, INSTR_BIT_SET);
      w(0);
      e = exp_f(ops[i], ad);
      chk(32'({nvm_op_o, nvm_units_o}), 32'({e[10:8], e[5:0]}));
      if (e[5:0] != 6'h00) chk(32'({nvm_region_o, nvm_addr_o}), 32'({e[7:6], ad}));
      poll();
      chk(32'(rd[START_BIT]), 32'h1);
      k = 0;
      while (rd[START_BIT] !== 1'b0 && k < 12) begin
        poll();
        k++;
      end
      chk(32'(rd[START_BIT]), 32'h0);
    end
    close_out();
  end
endmodule // testbench
